/* core/sync_burst_sram_port.sv */
// Synchronous flow-through burst SRAM port: strobes, burst counter, writes, tristate.
// Summary of operation
// - Processor strobe low captures address; low two bits start the burst counter.
// - Controller strobe low with first chip select low likewise captures address and starts the burst counter; with chip select high it deselects.
// - Both strobes low: only the processor strobe is acted upon.
// - Processor strobe ignored whenever first chip select is high.
// - Sleep input high enters low power, no accesses, contents kept.
// - Sleep held low or open for normal use; open reads inactive.
// - Incoming data lines are registered on the rising clock edge.
// - Reads drive the word at the address captured for that read.
// - Output enable low drives data lines; high tristates data and parity.
// - Tristate during write data phase, first clock after select, and deselected.
// - Parity lanes act as data lines, written under their byte's select.
// - Burst order strap low gives linear order, high or open interleaved.
// - Burst order strap is static during operation.
// - Global write low writes every lane, overriding byte enables and selects.
// - Byte selects, qualified by byte write enable, pick lanes to write.
// - Burst counter advances on each edge with advance input low while active and both strobes are high.
// - Two-bit counter wraps; linear adds one, interleaved XORs step with start.
`timescale 1ns/1ps
module sync_burst_sram_port
(
  input  wire logic                                   ref_clk_in,
  input  wire logic                                   rst_in,
  input  wire logic [burst_sram_pkg::ADDR_W-1:0]      addr_in,
  input  wire logic                                   processor_addr_strobe_n_in,
  input  wire logic                                   controller_addr_strobe_n_in,
  input  wire logic                                   chip_select_first_n_in,
  input  wire logic                                   global_write_n_in,
  input  wire logic                                   byte_write_enable_n_in,
  input  wire logic [burst_sram_pkg::LANES-1:0]       byte_select_n_in,
  input  wire logic                                   burst_advance_n_in,
  input  wire logic                                   output_enable_n_in,
  input  wire logic                                   sleep_request_in,
  input  wire logic                                   burst_order_in,
  input  wire logic [burst_sram_pkg::DATA_W-1:0]      data_in,
  input  wire logic [burst_sram_pkg::LANES-1:0]       parity_data_in,
  output logic      [burst_sram_pkg::DATA_W-1:0]      data_out,
  output logic                                        data_oe_out,
  output logic      [burst_sram_pkg::LANES-1:0]       parity_data_out,
  output logic                                        parity_oe_out
);
  burst_sram_pkg::port_state_t            state;
  burst_sram_pkg::port_state_t            next_state;
  logic [burst_sram_pkg::ADDR_W-1:0]      base;
  logic [burst_sram_pkg::ADDR_W-1:0]      next_base;
  logic [1:0]                             count;
  logic [1:0]                             next_count;
  logic                                   interleave;
  logic                                   next_interleave;
  logic                                   strap_taken;
  logic                                   next_strap_taken;
  logic                                   drive;
  logic                                   next_drive;
  logic                                   awake;
  logic                                   proc_take;
  logic                                   ctrl_take;
  logic                                   ctrl_select;
  logic                                   continue_cycle;
  logic [burst_sram_pkg::LANES-1:0]       lanes;
  logic [burst_sram_pkg::LANES-1:0]       lane_we;
  logic [burst_sram_pkg::ADDR_W-1:0]      cur_addr;
  logic [burst_sram_pkg::ADDR_W-1:0]      wr_addr;
  logic [burst_sram_pkg::ADDR_W-1:0]      rd_addr;
  logic [burst_sram_pkg::WORD_W-1:0]      wr_word;
  logic [burst_sram_pkg::WORD_W-1:0]      rd_word;

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // Global write overrides the byte controls; otherwise the byte enable gates
  // the selects.
  function automatic logic [burst_sram_pkg::LANES-1:0] write_lanes
  (
    input logic                             gw_n,
    input logic                             bwe_n,
    input logic [burst_sram_pkg::LANES-1:0] sel_n
  );
    if (!gw_n)
      return burst_sram_pkg::LANES_ALL;
    else if (!bwe_n)
      return ~sel_n;
    else
      return burst_sram_pkg::LANES_NONE;
  endfunction

  function automatic logic [burst_sram_pkg::ADDR_W-1:0] burst_addr
  (
    input logic [burst_sram_pkg::ADDR_W-1:0] start,
    input logic [1:0]                        step,
    input logic                              ilv
  );
    logic [1:0] low;
    low = ilv ? (start[1:0] ^ step) : 2'(start[1:0] + step);
    return {start[burst_sram_pkg::ADDR_W-1:2], low};
  endfunction

  // ==========================================================================
  // Access decode
  // ==========================================================================
  always_comb
  begin
    awake          = !sleep_request_in && (state != burst_sram_pkg::ST_SLEEP);
    proc_take      = awake && !processor_addr_strobe_n_in
                     && !chip_select_first_n_in;
    ctrl_take      = awake && !controller_addr_strobe_n_in
                     && processor_addr_strobe_n_in;
    ctrl_select    = ctrl_take && !chip_select_first_n_in;
    continue_cycle = awake && (state == burst_sram_pkg::ST_ACTIVE)
                     && processor_addr_strobe_n_in && controller_addr_strobe_n_in;
    lanes          = write_lanes(global_write_n_in, byte_write_enable_n_in,
                                 byte_select_n_in);
    lane_we        = (ctrl_select || continue_cycle) ? lanes : burst_sram_pkg::LANES_NONE;
    cur_addr       = burst_addr(base, count, interleave);
    wr_addr        = ctrl_select ? addr_in : cur_addr;
  end

  for (genvar k = 0; k < burst_sram_pkg::LANES; k++)
  begin : g_pack
    assign wr_word[k*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
      {parity_data_in[k], data_in[k*8 +: 8]};
    assign data_out[k*8 +: 8]  = rd_word[k*burst_sram_pkg::LANE_W +: 8];
    assign parity_data_out[k]  = rd_word[k*burst_sram_pkg::LANE_W + 8];
  end

  // ==========================================================================
  // Next state, address, counter and drive
  // ==========================================================================
  always_comb
  begin
    next_state       = state;
    next_base        = base;
    next_count       = count;
    next_strap_taken = 1'b1;
    next_interleave  = strap_taken ? interleave : burst_order_in;
    if (sleep_request_in)
      next_state = burst_sram_pkg::ST_SLEEP;
    else if (state == burst_sram_pkg::ST_SLEEP)
      next_state = burst_sram_pkg::ST_DESELECTED;
    else if (proc_take || ctrl_select)
      next_state = burst_sram_pkg::ST_ACTIVE;
    else if (ctrl_take)
      next_state = burst_sram_pkg::ST_DESELECTED;
    if (proc_take || ctrl_select)
    begin
      next_base  = addr_in;
      next_count = burst_sram_pkg::COUNT_RESET;
    end
    else if (continue_cycle && !burst_advance_n_in)
      next_count = 2'(count + burst_sram_pkg::COUNT_STEP);
    rd_addr    = burst_addr(next_base, next_count, next_interleave);
    next_drive = (next_state == burst_sram_pkg::ST_ACTIVE)
                 && (state == burst_sram_pkg::ST_ACTIVE)
                 && (lane_we == burst_sram_pkg::LANES_NONE)
                 && !output_enable_n_in;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state       <= burst_sram_pkg::ST_DESELECTED;
      base        <= burst_sram_pkg::ADDR_RESET;
      count       <= burst_sram_pkg::COUNT_RESET;
      interleave  <= burst_sram_pkg::ORDER_RESET;
      strap_taken <= 1'b0;
      drive       <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      base        <= next_base;
      count       <= next_count;
      interleave  <= next_interleave;
      strap_taken <= next_strap_taken;
      drive       <= next_drive;
    end
  end

  assign data_oe_out   = drive;
  assign parity_oe_out = drive;

  burst_sram_array u_array
  (
    .ref_clk_in  (ref_clk_in),
    .lane_we_in  (lane_we),
    .wr_addr_in  (wr_addr),
    .wr_data_in  (wr_word),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_word)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_proc_capture: assert property (proc_take |=> base == $past(addr_in)
    && count == burst_sram_pkg::COUNT_RESET) else $error("processor strobe missed");
  a_ctrl_capture: assert property (ctrl_select && !proc_take |=> base == $past(addr_in)
    && state == burst_sram_pkg::ST_ACTIVE) else $error("controller strobe missed");
  a_strobe_priority: assert property (!processor_addr_strobe_n_in
    && !controller_addr_strobe_n_in && !chip_select_first_n_in && awake
    |-> lane_we == 4'h0 ##1 base == $past(addr_in))
    else $error("controller strobe not masked");
  a_select_gate: assert property (chip_select_first_n_in && controller_addr_strobe_n_in
    |=> $stable(base)) else $error("strobe taken while unselected");
  a_sleep_quiet: assert property (sleep_request_in |-> lane_we == 4'h0
    ##1 !data_oe_out [*2]) else $error("access during sleep");
  a_oe_tristate: assert property (output_enable_n_in |=> !data_oe_out && !parity_oe_out)
    else $error("driving with output enable high");
  a_write_tristate: assert property (lane_we != 4'h0 |=> !data_oe_out)
    else $error("driving during write");
  a_first_clock: assert property (state != burst_sram_pkg::ST_ACTIVE |=> !data_oe_out)
    else $error("driving in first selected clock");
  a_global_all: assert property (continue_cycle && !global_write_n_in |-> lane_we == 4'hf)
    else $error("global write lost lanes");
  a_advance_step: assert property (continue_cycle && !burst_advance_n_in
    |=> count == 2'($past(count) + 2'h1)) else $error("counter did not advance");
  a_hold_value: assert property (!proc_take && !ctrl_select && burst_advance_n_in
    |=> $stable(count) && $stable(base)) else $error("address changed idly");

  c_proc_read: cover property (proc_take ##1 continue_cycle ##1 data_oe_out);
  c_ctrl_write: cover property (ctrl_select && lane_we != 4'h0);
  c_burst_wrap: cover property (continue_cycle && !burst_advance_n_in && count == 2'h3);
  c_sleep: cover property (state == burst_sram_pkg::ST_SLEEP ##1
    state == burst_sram_pkg::ST_DESELECTED);
endmodule

/* core/burst_sram_pkg.sv */
// Shared widths, reset values and state codes of the burst SRAM port.
package burst_sram_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int WORD_W = LANES * LANE_W;

  localparam logic [1:0]        COUNT_RESET = 2'h0;
  localparam logic [1:0]        COUNT_STEP  = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 20'h00000;
  localparam logic [LANES-1:0]  LANES_ALL   = 4'hf;
  localparam logic [LANES-1:0]  LANES_NONE  = 4'h0;
  localparam logic              ORDER_RESET = 1'b1;

  typedef enum logic [2:0]
  {
    ST_DESELECTED = 3'h1,
    ST_ACTIVE     = 3'h2,
    ST_SLEEP      = 3'h4
  } port_state_t;
endpackage

/* core/burst_sram_array.sv */
// Byte-lane writable storage array with a registered read port.
`timescale 1ns/1ps
module burst_sram_array
(
  input  wire logic                                   ref_clk_in,
  input  wire logic [burst_sram_pkg::LANES-1:0]       lane_we_in,
  input  wire logic [burst_sram_pkg::ADDR_W-1:0]      wr_addr_in,
  input  wire logic [burst_sram_pkg::WORD_W-1:0]      wr_data_in,
  input  wire logic [burst_sram_pkg::ADDR_W-1:0]      rd_addr_in,
  output logic      [burst_sram_pkg::WORD_W-1:0]      rd_data_out
);
  logic [burst_sram_pkg::WORD_W-1:0] store [0:(1 << burst_sram_pkg::ADDR_W)-1];

  always_ff @(posedge ref_clk_in)
  begin
    rd_data_out <= store[rd_addr_in];
  end

  // One process writes every lane so that the array has a single driver.
  always_ff @(posedge ref_clk_in)
  begin
    for (int k = 0; k < burst_sram_pkg::LANES; k++)
    begin
      if (lane_we_in[k])
      begin
        store[wr_addr_in][k*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] <=
          wr_data_in[k*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
      end
    end
  end
endmodule

/* tb/bus_master_model.sv */
// Bus master model that drives the port and resolves the shared data and parity lines.
`timescale 1ns/1ps
module bus_master_model
(
  input  wire logic        ref_clk_in,
  input  wire logic [31:0] rd_data_in,
  input  wire logic [3:0]  rd_parity_in,
  input  wire logic        rd_oe_in,
  output logic      [19:0] addr_out,
  output logic      [7:0]  ctl_out,
  output logic      [3:0]  sel_n_out,
  output logic      [31:0] data_out,
  output logic      [3:0]  parity_out
);
  logic [35:0] wr_word;
  logic [35:0] last;
  logic [35:0] line;
  logic        drive;

  // A released line shows the inverse of its last level, never a stale copy.
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (drive)
        line[9*k +: 9] = wr_word[9*k +: 9];
      else if (rd_oe_in)
        line[9*k +: 9] = {rd_parity_in[k], rd_data_in[8*k +: 8]};
      else
        line[9*k +: 9] = ~last[9*k +: 9];
      data_out[8*k +: 8] = line[9*k +: 8];
      parity_out[k]      = line[9*k + 8];
    end
  end

  always @(posedge ref_clk_in)
    last <= line;

  initial
  begin
    ctl_out   = 8'hfc;
    addr_out  = 20'h0;
    sel_n_out = 4'hf;
    wr_word   = 36'h0;
    drive     = 1'b0;
    last      = 36'h0;
  end

  // Control bits: strobe p, strobe c, select, global write, byte enable, advance, oe, sleep.
  task automatic cyc(input logic [7:0] c, input logic [19:0] a, input logic [35:0] w,
                     input logic [3:0] s);
    @(posedge ref_clk_in);
    #1;
    ctl_out   = c;
    addr_out  = a;
    wr_word   = w;
    sel_n_out = s;
    drive     = !c[4] || !c[3];
  endtask
endmodule

/* tb/test_sync_burst_sram_port.sv */
// Self-checking testbench of the synchronous burst SRAM port.
`timescale 1ns/1ps
module test_sync_burst_sram_port;
  localparam logic [19:0] BASE = 20'ha4a4;
  localparam logic [7:0]  IDL = 8'hfc, BURST_ADVANCE_N = 8'hf8, PRD = 8'h5c, GWR = 8'h8c, BWR = 8'h94;
  localparam logic [7:0]  CRD = 8'h9c, DSL = 8'hbc, BOTH = 8'h0c, PCS = 8'h7c, OEH = 8'hfa;
  localparam logic [7:0]  SLP = 8'hfd, CWB = 8'hf6;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        strap = 1'b1;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [35:0] mem [4];
  logic [19:0] addr;
  logic [7:0]  ctl;
  logic [3:0]  sel;
  logic [31:0] wd;
  logic [3:0]  wp;
  logic [31:0] rd;
  logic [3:0]  rp;
  logic        doe;
  logic        poe;

  always #20 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  bus_master_model bus_master_model_inst (.ref_clk_in(ref_clk_in), .rd_data_in(rd),
    .rd_parity_in(rp), .rd_oe_in(doe), .addr_out(addr), .ctl_out(ctl), .sel_n_out(sel),
    .data_out(wd), .parity_out(wp));

  sync_burst_sram_port sync_burst_sram_port_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .addr_in(addr), .processor_addr_strobe_n_in(ctl[7]), .controller_addr_strobe_n_in(ctl[6]),
    .chip_select_first_n_in(ctl[5]), .global_write_n_in(ctl[4]),
    .byte_write_enable_n_in(ctl[3]), .byte_select_n_in(sel), .burst_advance_n_in(ctl[2]),
    .output_enable_n_in(ctl[1]), .sleep_request_in(ctl[0]), .burst_order_in(strap),
    .data_in(wd), .parity_data_in(wp), .data_out(rd), .data_oe_out(doe),
    .parity_data_out(rp), .parity_oe_out(poe));

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [35:0] got();
    for (int k = 0; k < 4; k++)
      got[9*k +: 9] = {rp[k], rd[8*k +: 8]};
  endfunction

  task automatic cyc(input logic [7:0] c, input logic [19:0] a);
    bus_master_model_inst.cyc(c, a, 36'h0, 4'hf);
  endtask

  task automatic do_reset(input logic s);
    strap = s;
    rst_in = 1'b1;
    repeat (12) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    cyc(IDL, BASE);
    cyc(IDL, BASE);
  endtask

  task automatic t_gw_write();
    for (int i = 0; i < 4; i++)
    begin
      mem[i] = 36'h936c5a5a0 + 36'(i * 16'h1111);
      bus_master_model_inst.cyc(GWR, BASE + 20'(i), mem[i], 4'hf);
    end
    cyc(IDL, BASE);
    check(36'(doe), 36'h0);
    $display("t_gw_write done");
  endtask

  task automatic t_read(input logic [1:0] lo, input logic ilv);
    logic [1:0] idx;
    cyc(DSL, BASE);
    cyc(PRD, BASE + 20'(lo));
    for (int k = 0; k < 4; k++)
    begin
      idx = ilv ? lo ^ 2'(k) : lo + 2'(k);
      cyc(k == 3 ? IDL : BURST_ADVANCE_N, BASE);
      check(got(), mem[idx]);
      check(36'(doe), 36'(k != 0));
      check(36'(poe), 36'(k != 0));
    end
    cyc(IDL, BASE);
    check(got(), mem[idx]);
    $display("t_read done");
  endtask

  task automatic t_byte_write();
    logic [35:0] w;
    w = 36'h1e3c78f0f;
    bus_master_model_inst.cyc(BWR, BASE + 20'h2, w, 4'ha);
    mem[2][8:0] = w[8:0];
    mem[2][26:18] = w[26:18];
    cyc(CRD, BASE + 20'h2);
    cyc(IDL, BASE);
    check(got(), mem[2]);
    $display("t_byte_write done");
  endtask

  task automatic t_burst_write();
    logic [35:0] w;
    w = 36'h0f1e2d3c4;
    cyc(PRD, BASE + 20'h1);
    bus_master_model_inst.cyc(CWB, BASE, w, 4'h5);
    mem[1][17:9] = w[17:9];
    mem[1][35:27] = w[35:27];
    bus_master_model_inst.cyc(IDL, BASE, ~w, 4'h0);
    check(36'(doe), 36'h0);
    cyc(CRD, BASE + 20'h1);
    cyc(IDL, BASE);
    check(got(), mem[1]);
    $display("t_burst_write done");
  endtask

  task automatic t_priority();
    bus_master_model_inst.cyc(BOTH, BASE + 20'h3, ~mem[3], 4'hf);
    cyc(CRD, BASE + 20'h3);
    cyc(PCS, BASE);
    check(got(), mem[3]);
    cyc(BURST_ADVANCE_N, BASE);
    cyc(IDL, BASE);
    check(got(), mem[2]);
    $display("t_priority done");
  endtask

  task automatic t_oe_sleep();
    cyc(OEH, BASE);
    cyc(IDL, BASE);
    check(36'(doe), 36'h0);
    check(36'(poe), 36'h0);
    cyc(SLP, BASE);
    cyc(IDL, BASE);
    check(36'(doe), 36'h0);
    cyc(IDL, BASE);
    cyc(IDL, BASE);
    $display("t_oe_sleep done");
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    do_reset(1'b1);
    t_gw_write();
    t_read(2'h1, 1'b1);
    t_byte_write();
    t_burst_write();
    t_priority();
    t_oe_sleep();
    do_reset(1'b0);
    t_read(2'h1, 1'b0);
    t_read(2'h3, 1'b0);
    report_and_stop();
  end
endmodule
